/* File: core/macrc_regs.sv */
/*
  Control and status register bank of an embedded Ethernet MAC.
  Assumes a synchronous host port (one-cycle strobes, read data one cycle
  later) and a receive datapath that pulses end-of-frame with its flags.
*/
// Chosen here: the address-and-strobe port.
// ==========================================================
module macrc_regs
  import macrc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // host register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // receive datapath event at frame end
  input wire logic RX_END,
  input wire logic RX_DA_MATCH,
  input wire logic RX_DA_UNICAST,
  input wire logic RX_DA_MCAST,
  input wire logic RX_DA_BCAST,
  input wire logic RX_HASH_HIT,
  input wire logic RX_RUNT,
  input wire logic RX_FCS_ERR,
  input wire logic RX_ALIGN_ERR,
  input wire logic RX_NO_BUFFER,
  input wire logic RX_DISABLED,
  // other status sources
  input wire logic INT_PHY_USED,
  input wire logic MEDIA_DUPLEX,
  input wire logic [6:0] IRQ_PENDING,
  // controls to the MAC
  output logic RX_ACCEPT,
  output logic RX_STORE,
  output logic FULL_DUPLEX,
  output logic TX_PAD_EN,
  output logic TX_LATE_RETRY,
  output logic [1:0] LOOPBACK_MODE,
  output logic TX_FCS_EN,
  output logic WORD_PORT,
  output logic TALLY_OVF,
  output logic IRQ
);
  // ==========================================================
  // registers
  logic [7:0] rx_config_r;
  logic [7:0] rx_state_r;
  logic [7:0] tx_config_r;
  logic [7:0] align_tally_r;
  logic [7:0] fcs_tally_r;
  logic [7:0] data_port_config_r;
  logic [7:0] irq_enable_mask_r;
  logic [7:0] rdata_nxt;
  logic accept_nxt;
  logic rd_align;
  logic rd_fcs;
  logic [6:0] irq_hit;

  assign rd_align = RD && (ADDR == OFS_ALIGN_TALLY);
  assign rd_fcs = RD && (ADDR == OFS_FCS_TALLY);

  // ==========================================================
  // write side
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_config_r <= RESET_BYTE;
      tx_config_r <= RESET_BYTE;
      data_port_config_r <= RESET_BYTE;
      irq_enable_mask_r <= RESET_BYTE;
    end else if (WR) begin
      // reserved bits dropped; host should write them zero
      if (ADDR == OFS_RX_CONFIG) begin
        rx_config_r <= WDATA & RX_CONFIG_MASK;
      end else if (ADDR == OFS_TX_CONFIG) begin
        tx_config_r <= WDATA & TX_CONFIG_MASK;
      end else if (ADDR == OFS_DATA_PORT_CONFIG) begin
        data_port_config_r <= WDATA & DATA_PORT_MASK;
      end else if (ADDR == OFS_IRQ_ENABLE_MASK) begin
        irq_enable_mask_r <= WDATA & IRQ_MASK_MASK;
      end
    end
  end

  // ==========================================================
  // address acceptance
  always_comb begin
    accept_nxt = 1'b0;
    if (RX_DA_BCAST) begin
      accept_nxt = rx_config_r[B_BCAST_ACCEPT];
    end else if (RX_DA_MCAST) begin
      accept_nxt = rx_config_r[B_MCAST_ACCEPT] && RX_HASH_HIT;
    end else if (RX_DA_UNICAST) begin
      accept_nxt = RX_DA_MATCH || rx_config_r[B_ALL_UNICAST];
    end
    if (RX_RUNT && !rx_config_r[B_RUNT_ACCEPT]) begin
      accept_nxt = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RX_ACCEPT <= 1'b0;
      RX_STORE <= 1'b0;
    end else if (RX_END) begin
      RX_ACCEPT <= accept_nxt;
      // listen-only still checks but never stores
      RX_STORE <= accept_nxt && !rx_config_r[B_LISTEN_ONLY]
        && (!(RX_FCS_ERR || RX_ALIGN_ERR)
        || rx_config_r[B_KEEP_ERR]);
    end else begin
      RX_ACCEPT <= 1'b0;
      RX_STORE <= 1'b0;
    end
  end

  // ==========================================================
  // receive status
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_state_r <= RESET_BYTE;
    end else if (RX_END) begin
      rx_state_r <= RESET_BYTE;
      rx_state_r[B_RX_OFF] <= RX_DISABLED;
      rx_state_r[B_MC_BC] <= RX_DA_MCAST || RX_DA_BCAST;
      rx_state_r[B_MISSED] <= RX_NO_BUFFER;
      rx_state_r[B_ALIGN_ERR] <= RX_ALIGN_ERR;
      rx_state_r[B_FCS_ERR] <= RX_FCS_ERR;
      rx_state_r[B_FRAME_OK] <= !(RX_ALIGN_ERR || RX_FCS_ERR);
    end else begin
      rx_state_r[B_RX_OFF] <= RX_DISABLED;
    end
  end

  // ==========================================================
  // error tallies; a read in the increment cycle clears the old count and keeps the new frame, leaving 1
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      align_tally_r <= RESET_BYTE;
    end else if (RX_END && accept_nxt && RX_ALIGN_ERR) begin
      align_tally_r <= rd_align ? 8'h01 : align_tally_r + 8'h01;
    end else if (rd_align) begin
      align_tally_r <= RESET_BYTE;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fcs_tally_r <= RESET_BYTE;
    end else if (RX_END && accept_nxt && RX_FCS_ERR) begin
      fcs_tally_r <= rd_fcs ? 8'h01 : fcs_tally_r + 8'h01;
    end else if (rd_fcs) begin
      fcs_tally_r <= RESET_BYTE;
    end
  end

  // ==========================================================
  // read port
  always_comb begin
    rdata_nxt = RESET_BYTE;
    if (ADDR == OFS_RX_STATE) begin
      rdata_nxt = rx_state_r;
    end else if (ADDR == OFS_ALIGN_TALLY) begin
      rdata_nxt = align_tally_r;
    end else if (ADDR == OFS_FCS_TALLY) begin
      rdata_nxt = fcs_tally_r;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= RESET_BYTE;
    end else begin
      RDATA <= RD ? rdata_nxt : RESET_BYTE;
    end
  end

  // ==========================================================
  // MAC controls
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      FULL_DUPLEX <= 1'b0;
      TX_PAD_EN <= 1'b1;
      TX_LATE_RETRY <= 1'b0;
      LOOPBACK_MODE <= MACRC_LB_NORMAL;
      TX_FCS_EN <= 1'b1;
      WORD_PORT <= 1'b0;
      TALLY_OVF <= 1'b0;
    end else begin
      // integrated PHY resolves duplex itself
      FULL_DUPLEX <= !INT_PHY_USED
        && (tx_config_r[B_FULL_DUPLEX] || MEDIA_DUPLEX);
      TX_PAD_EN <= !tx_config_r[B_PAD_OFF];
      TX_LATE_RETRY <= tx_config_r[B_LATE_RETRY];
      LOOPBACK_MODE <= tx_config_r[B_LOOP_HI:B_LOOP_LO];
      TX_FCS_EN <= !tx_config_r[B_FCS_INHIBIT];
      WORD_PORT <= data_port_config_r[B_WORD_WIDTH];
      TALLY_OVF <= align_tally_r[7] || fcs_tally_r[7];
    end
  end

  // ==========================================================
  // interrupt gating per source
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_SOURCES; gi++) begin : g_irq
      assign irq_hit[gi] = IRQ_PENDING[gi] && irq_enable_mask_r[gi];
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |irq_hit;
    end
  end

  // ==========================================================
  // checks
  property p_listen_no_store;
    @(posedge REF_CLK) disable iff (!RSTN)
    rx_config_r[B_LISTEN_ONLY] && RX_END |=> !RX_STORE;
  endproperty
  a_listen_no_store: assert property (p_listen_no_store)
    else $error("frame stored in listen-only mode");

  property p_bcast;
    @(posedge REF_CLK) disable iff (!RSTN)
    RX_END && RX_DA_BCAST && !RX_RUNT
      |=> RX_ACCEPT == $past(rx_config_r[B_BCAST_ACCEPT]);
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast acceptance wrong");

  property p_mcast;
    @(posedge REF_CLK) disable iff (!RSTN)
    RX_END && RX_DA_MCAST && !RX_DA_BCAST && !RX_HASH_HIT |=> !RX_ACCEPT;
  endproperty
  a_mcast: assert property (p_mcast)
    else $error("multicast accepted without hash hit");

  property p_runt;
    @(posedge REF_CLK) disable iff (!RSTN)
    RX_END && RX_RUNT && !rx_config_r[B_RUNT_ACCEPT] |=> !RX_ACCEPT;
  endproperty
  a_runt: assert property (p_runt)
    else $error("runt accepted while disabled");

  property p_duplex;
    @(posedge REF_CLK) disable iff (!RSTN)
    ##1 FULL_DUPLEX == $past(!INT_PHY_USED
      && (tx_config_r[B_FULL_DUPLEX] || MEDIA_DUPLEX));
  endproperty
  a_duplex: assert property (p_duplex)
    else $error("duplex selection wrong");

  property p_tally_clear;
    @(posedge REF_CLK) disable iff (!RSTN)
    rd_align && !RX_END ##1 !RX_END |=> align_tally_r == 8'h00;
  endproperty
  a_tally_clear: assert property (p_tally_clear)
    else $error("alignment tally not cleared by read");

  property p_fcs_count;
    @(posedge REF_CLK) disable iff (!RSTN)
    RX_END && accept_nxt && RX_FCS_ERR && !rd_fcs
      |=> fcs_tally_r == $past(fcs_tally_r) + 8'h01;
  endproperty
  a_fcs_count: assert property (p_fcs_count)
    else $error("fcs tally did not increment");

  property p_reject_no_count;
    @(posedge REF_CLK) disable iff (!RSTN)
    RX_END && !accept_nxt && !rd_align |=> $stable(align_tally_r);
  endproperty
  a_reject_no_count: assert property (p_reject_no_count)
    else $error("tally counted unaccepted frame");

  property p_irq;
    @(posedge REF_CLK) disable iff (!RSTN)
    (irq_enable_mask_r[6:0] & IRQ_PENDING) == 7'h00 |=> !IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without enabled source");

  property p_state_bit3;
    @(posedge REF_CLK) disable iff (!RSTN)
    RD && ADDR == OFS_RX_STATE |=> !RDATA[3];
  endproperty
  a_state_bit3: assert property (p_state_bit3)
    else $error("rx_state bit 3 not zero");

  property p_unicast;
    @(posedge REF_CLK) disable iff (!RSTN)
    RX_END && RX_DA_UNICAST && !RX_DA_MCAST && !RX_DA_BCAST && !RX_RUNT
      && rx_config_r[B_ALL_UNICAST] |=> RX_ACCEPT;
  endproperty
  a_unicast: assert property (p_unicast)
    else $error("unicast frame not accepted in accept-all mode");

  property p_err_store;
    @(posedge REF_CLK) disable iff (!RSTN)
    RX_END && (RX_FCS_ERR || RX_ALIGN_ERR) && !rx_config_r[B_KEEP_ERR]
      |=> !RX_STORE;
  endproperty
  a_err_store: assert property (p_err_store)
    else $error("error frame stored without keep-error-frames");

  property p_fcs_inhibit;
    @(posedge REF_CLK) disable iff (!RSTN)
    ##1 TX_FCS_EN == !$past(tx_config_r[B_FCS_INHIBIT]);
  endproperty
  a_fcs_inhibit: assert property (p_fcs_inhibit)
    else $error("fcs append control wrong");

  // read and increment in one cycle: the increment must survive
  property p_tally_race;
    @(posedge REF_CLK) disable iff (!RSTN)
    rd_align && RX_END && accept_nxt && RX_ALIGN_ERR
      |=> align_tally_r == 8'h01;
  endproperty
  a_tally_race: assert property (p_tally_race)
    else $error("tally increment lost to a coincident read");

  c_store: cover property (@(posedge REF_CLK) RX_STORE);
  c_align_read: cover property (@(posedge REF_CLK)
    align_tally_r != 8'h00 ##1 rd_align);
  c_irq: cover property (@(posedge REF_CLK) IRQ);
  c_tally_race: cover property (@(posedge REF_CLK) rd_align && RX_END);
endmodule // macrc_regs

/* File: core/macrc_pkg.sv */
/*
  Package for the MAC receive/transmit configuration and status registers:
  offsets, field positions, reset values and encodings.
  Assumes a byte-wide register port with 4-bit offsets.
*/
package macrc_pkg;
  // ==========================================================
  // register offsets (write and read share offsets)
  localparam logic [3:0] OFS_RX_CONFIG = 4'hc;
  localparam logic [3:0] OFS_RX_STATE = 4'hc;
  localparam logic [3:0] OFS_TX_CONFIG = 4'hd;
  localparam logic [3:0] OFS_ALIGN_TALLY = 4'hd;
  localparam logic [3:0] OFS_DATA_PORT_CONFIG = 4'he;
  localparam logic [3:0] OFS_FCS_TALLY = 4'he;
  localparam logic [3:0] OFS_IRQ_ENABLE_MASK = 4'hf;
  // ==========================================================
  // rx_config fields
  localparam int B_LISTEN_ONLY = 5;
  localparam int B_ALL_UNICAST = 4;
  localparam int B_MCAST_ACCEPT = 3;
  localparam int B_BCAST_ACCEPT = 2;
  localparam int B_RUNT_ACCEPT = 1;
  localparam int B_KEEP_ERR = 0;
  localparam logic [7:0] RX_CONFIG_MASK = 8'h3f;
  // rx_state fields
  localparam int B_RX_OFF = 6;
  localparam int B_MC_BC = 5;
  localparam int B_MISSED = 4;
  localparam int B_ALIGN_ERR = 2;
  localparam int B_FCS_ERR = 1;
  localparam int B_FRAME_OK = 0;
  // tx_config fields
  localparam int B_FULL_DUPLEX = 7;
  localparam int B_PAD_OFF = 6;
  localparam int B_LATE_RETRY = 5;
  localparam int B_LOOP_HI = 2;
  localparam int B_LOOP_LO = 1;
  localparam int B_FCS_INHIBIT = 0;
  localparam logic [7:0] TX_CONFIG_MASK = 8'he7;
  // data_port_config fields
  localparam int B_WORD_WIDTH = 0;
  localparam logic [7:0] DATA_PORT_MASK = 8'h01;
  // irq_enable_mask: bit 6 dma done .. bit 0 rx done
  localparam int IRQ_SOURCES = 7;
  localparam logic [7:0] IRQ_MASK_MASK = 8'h7f;
  // ==========================================================
  // reset values and misc
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hff;
  localparam int MIN_FRAME_BYTES = 60;
  typedef enum logic [1:0] {
    MACRC_LB_NORMAL, MACRC_LB_MAC, MACRC_LB_PHY, MACRC_LB_RSVD
  } macrc_loop_t;
endpackage : macrc_pkg

/* File: test/macrc_host.sv */
/*
  host model: drives the register port of the bank.
  assumes one clock and one-cycle strobes at its rising edge.
*/
module macrc_host
  import macrc_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // ==========================================================
  // bus cycles
  // released lines show inverted junk, never the last value
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule // macrc_host

/* File: test/test_mac_rxtx_config_status_regs.sv */
/*
  self-checking bench of the mac register bank.
  assumes the host model beside it and a 50 MHz clock.
*/
module test_mac_rxtx_config_status_regs;
  import macrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [8:0] M = 9'h100, U = 9'h080, MC = 9'h040;
  localparam logic [8:0] BC = 9'h020, H = 9'h010, RU = 9'h008;
  localparam logic [8:0] FE = 9'h004, AE = 9'h002, NB = 9'h001;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_end = 1'b0, rx_off = 1'b0, int_phy = 1'b0, mdup = 1'b0;
  logic [8:0] fl = 9'h000;
  logic [6:0] pend = 7'h7f;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, outs;
  logic wr, rd, acc, sto, fdx, pad, lret, fcs, wport, ovf, irq;
  logic [1:0] loop;
  int n_fail = 0, checks_done = 0, cyc = 0;
  always #10 clk = ~clk;
  assign outs = {fdx, pad, lret, loop, fcs, wport, irq};
  macrc_host macrc_host_inst (.clk(clk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  macrc_regs macrc_regs_inst (.REF_CLK(clk), .RSTN(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_END(rx_end),
    .RX_DA_MATCH(fl[8]), .RX_DA_UNICAST(fl[7]), .RX_DA_MCAST(fl[6]),
    .RX_DA_BCAST(fl[5]), .RX_HASH_HIT(fl[4]), .RX_RUNT(fl[3]),
    .RX_FCS_ERR(fl[2]), .RX_ALIGN_ERR(fl[1]), .RX_NO_BUFFER(fl[0]),
    .RX_DISABLED(rx_off), .INT_PHY_USED(int_phy), .MEDIA_DUPLEX(mdup),
    .IRQ_PENDING(pend), .RX_ACCEPT(acc), .RX_STORE(sto),
    .FULL_DUPLEX(fdx), .TX_PAD_EN(pad), .TX_LATE_RETRY(lret),
    .LOOPBACK_MODE(loop), .TX_FCS_EN(fcs), .WORD_PORT(wport),
    .TALLY_OVF(ovf), .IRQ(irq));
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    macrc_host_inst.wr_reg(a, d);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a,
    input logic [7:0] e);
    logic [7:0] d;
    macrc_host_inst.rd_reg(a, d);
    chk(nm, e, d);
  endtask
  // output flops land one edge after the config register
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // flags are junk outside the end-of-frame pulse
  task automatic frame(input logic [8:0] f);
    @(posedge clk);
    rx_end <= 1'b1;
    fl <= f;
    @(posedge clk);
    rx_end <= 1'b0;
    fl <= ~f;
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    #1;
    chk("outs", 8'h44, outs);
    rchk("rx_state", 4'hc, 8'h00);
    rchk("align", 4'hd, 8'h00);
    rchk("fcs", 4'he, 8'h00);
    rchk("mask", 4'hf, 8'h00);
    rchk("unmapped", 4'h3, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_tx;
    wreg(4'hd, 8'he5);
    settle;
    chk("tx", 8'hb0, outs);
    for (int i = 0; i < 3; i++) begin
      wreg(4'hd, {5'h00, i[1:0], 1'b0});
      settle;
      chk("loop", i[7:0], {6'h00, loop});
    end
    @(posedge clk) mdup <= 1'b1;
    settle;
    chk("mdup", 8'h01, {7'h00, fdx});
    @(posedge clk) int_phy <= 1'b1;
    wreg(4'hd, 8'h80);
    settle;
    chk("phy", 8'h00, {7'h00, fdx});
    @(posedge clk) int_phy <= 1'b0;
    mdup <= 1'b0;
    settle;
    chk("tdup", 8'h01, {7'h00, fdx});
    wreg(4'hd, 8'h00);
    wreg(4'he, 8'h01);
    settle;
    chk("port", 8'h46, outs);
    wreg(4'he, 8'h00);
    $display("tx test done");
  endtask
  task automatic t_accept;
    logic [7:0] cf[11] = '{8'h04, 8'h00, 8'h08, 8'h08, 8'h10, 8'h00,
      8'h00, 8'h02, 8'h00, 8'h01, 8'h20};
    logic [8:0] fr[11] = '{BC, BC, MC | H, MC, U, U, M | U | RU,
      M | U | RU, M | U | FE, M | U | FE, M | U};
    logic [1:0] ex[11] = '{2'b11, 2'b00, 2'b11, 2'b00, 2'b11, 2'b00,
      2'b00, 2'b11, 2'b10, 2'b11, 2'b10};
    for (int i = 0; i < 11; i++) begin
      wreg(4'hc, cf[i]);
      frame(fr[i]);
      chk("accept", {6'h00, ex[i]}, {6'h00, acc, sto});
    end
    $display("accept test done");
  endtask
  task automatic t_tally;
    logic [7:0] d;
    wreg(4'hc, 8'h00);
    macrc_host_inst.rd_reg(4'hd, d);
    macrc_host_inst.rd_reg(4'he, d);
    frame(U | AE);
    frame(U | FE);
    repeat (128) frame(M | U | AE);
    settle;
    chk("ovf", 8'h01, {7'h00, ovf});
    frame(M | U | FE | NB);
    @(posedge clk) rx_off <= 1'b1;
    settle;
    rchk("rx_state", 4'hc, 8'h52);
    rchk("align", 4'hd, 8'h80);
    rchk("align", 4'hd, 8'h00);
    rchk("fcs", 4'he, 8'h01);
    rchk("fcs", 4'he, 8'h00);
    frame(M | U | AE);
    // read lands on the same edge as an increment: set wins
    fork
      rchk("align", 4'hd, 8'h01);
      frame(M | U | AE);
    join
    rchk("align", 4'hd, 8'h01);
    settle;
    chk("ovf", 8'h00, {7'h00, ovf});
    $display("tally test done");
  endtask
  task automatic t_irq;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) pend <= 7'h7f ^ (7'h01 << i);
      wreg(4'hf, 8'h01 << i);
      settle;
      chk("irq", 8'h00, {7'h00, irq});
      @(posedge clk) pend <= 7'h01 << i;
      settle;
      chk("irq", 8'h01, {7'h00, irq});
    end
    wreg(4'hf, 8'h00);
    settle;
    chk("irq", 8'h00, {7'h00, irq});
    $display("irq test done");
  endtask
  // ==========================================================
  // run and watchdog
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      finish_test;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_tx;
    t_accept;
    t_tally;
    t_irq;
    finish_test;
  end
endmodule // test_mac_rxtx_config_status_regs
